// ---- battery_pack.sv ----
// battery pack model: measured charge current seen by the controller
`timescale 1ns/1ns
`default_nettype none
module battery_pack (
   input wire logic i_clk,            // system clock
   input wire logic i_switch_on,      // battery switch closed
   input wire logic i_full,           // cell near full, current tapers
   input wire logic [12:0] i_target,  // current target mA
   output logic [12:0] o_bat_ma       // measured current mA
);
   // current follows the target one cycle late; an open switch reads zero
   always_ff @(posedge i_clk) begin
      if (!i_switch_on) begin
         o_bat_ma <= 13'h0000;
      end else if (i_full) begin
         o_bat_ma <= 13'h0010;  // taper well below the termination level
      end else begin
         o_bat_ma <= i_target;
      end
   end
endmodule
`default_nettype wire

// ---- charge_ctrl.sv ----
// charge cycle controller: phases, termination, timer, indicator
`timescale 1ns/1ns
`default_nettype none
// Function
// [RULE_01] defaults 2048/128/256 mA, 12 hour timer
// [RULE_02] start needs enable, current, no faults
// [RULE_03] terminate on low current, high voltage
// [RULE_04] recharge below selectable recharge threshold
// [RULE_05] toggling enable restarts after done
// [RULE_06] indicator low/high/blink, disable bit
// [RULE_07] phase field 00/01/10/11
// [RULE_08] current picked from battery voltage
// [RULE_09] regulation suspends termination, halves timer
// [RULE_10] termination opens battery switch only
// [RULE_11] termination sets 11 and event pulse
// [RULE_12] termination enable bit zero inhibits
// [RULE_13] voltage target adds min compensation, clamp
// [RULE_14] thermistor window gates start and suspends
// [RULE_15] warm drops 200 mV, cool limits current
// [RULE_16] cool termination at 20 or 50 percent
// [RULE_17] boost suspends outside boost window
// [RULE_18] four hours low battery, else duration
// [RULE_19] expiry sets fault 11, enable bit
// [RULE_20] half rate disable bit
// [RULE_21] one-shot go bit self clears
// [RULE_22] continuous mode results every second
// [RULE_23] fault pulse once until read, cleared
// [RULE_24] half rate skips alternate ticks
// [RULE_25] result updates depend on mode
module charge_ctrl
   import charge_pkg::*;
#(
   parameter int PULSE_CYC = EVENT_PULSE_CYC,   // event pulse length
   parameter int MON_CYC = MONITOR_CYC,         // monitor pass length
   parameter int BLINK_CYC = BLINK_HALF_CYC,    // blink half period
   parameter int TICKS_PER_HOUR = 3600          // timebase ticks/hour
) (
   input wire logic I_CLK_SYS,                  // 20 MHz clock
   input wire logic I_RESET,                    // sync reset, high
   input wire logic I_TICK,                     // slow timebase tick
   input wire logic I_REG_RESET,                // register reset
   input wire logic I_CONV_RUN,                 // converter running
   input wire logic I_CHARGE_ENABLE_BIT,        // charge enable bit
   input wire logic I_CHARGE_EN_N,              // enable pin, async
   input wire logic I_FAST_CUR_WE,              // write fast current
   input wire logic [12:0] I_FAST_CUR_WDATA,    // fast current mA
   input wire logic [12:0] I_PRE_CUR,           // precharge current
   input wire logic [12:0] I_SHORT_CUR,         // short batt current
   input wire logic [12:0] I_TERM_CUR,          // termination current
   input wire logic [12:0] I_REG_VOLT,          // regulation voltage
   input wire logic [12:0] I_CLAMP_VOLT,        // compensation clamp
   input wire logic [7:0] I_COMP_RES,           // compensation mOhm
   input wire logic [12:0] I_BAT_MV,            // battery voltage
   input wire logic [12:0] I_BAT_MA,            // measured current
   input wire logic [12:0] I_RECHG_HI_MV,       // recharge level 0
   input wire logic [12:0] I_RECHG_LO_MV,       // recharge level 1
   input wire logic I_RECHARGE_SELECT,          // recharge select
   input wire logic [12:0] I_LOW_BAT_MV,        // low battery level
   input wire logic I_BATTERY_SWITCH_OFF,       // force switch off
   input wire logic I_TERM_ENABLE,              // termination enable
   input wire logic I_INPUT_LIMITING,           // power limiting
   input wire logic I_THERMAL_REG,              // thermal regulation
   input wire logic [2:0] I_TEMP_BAND,          // band_t from sense
   input wire logic I_WARM_VOLT_SELECT,         // warm voltage select
   input wire logic I_COOL_CUR_SELECT,          // 1: 50%, 0: 20%
   input wire logic I_COOL_TERM_REDUCE,         // 1: 50%, 0: 20%
   input wire logic I_BOOST_MODE,               // boost requested
   input wire logic I_BOOST_TEMP_OK,            // inside boost window
   input wire logic [1:0] I_BOOST_HOT_FIELD,    // boost hot field
   input wire logic I_TIMER_ENABLE,             // safety timer enable
   input wire logic I_HALF_RATE_ENABLE,         // half rate enable
   input wire logic I_TIMER_SEL_WE,             // write duration
   input wire logic [1:0] I_TIMER_SEL_WDATA,    // duration 5/8/12/20h
   input wire logic I_FAULT_READ,               // host read faults
   input wire logic I_INDICATOR_DISABLE,        // indicator disable
   input wire logic I_MON_GO_SET,               // monitor go write
   input wire logic I_MON_CONTINUOUS,           // monitor continuous
   output logic [12:0] O_FAST_CUR,              // fast current setting
   output logic [1:0] O_TIMER_SEL,              // timer duration field
   output logic [12:0] O_CUR_TARGET,            // current target mA
   output logic [12:0] O_VOLT_TARGET,           // voltage target mV
   output logic [1:0] O_PHASE,                  // charge phase field
   output logic [1:0] O_FAULT,                  // charge fault field
   output logic O_BATTERY_SWITCH_ON,            // battery switch
   output logic O_BOOST_RUN,                    // boost allowed
   output logic O_STAT_OUT,                     // indicator output
   output logic O_STAT_OE,                      // indicator drive low
   output logic O_EVENT,                        // host event pulse
   output logic O_MON_GO,                       // monitor go bit
   output logic O_UPD_COMMON,                   // batt/sys/ts update
   output logic O_UPD_INPUT,                    // input volt update
   output logic O_UPD_CURRENT                   // current update
);
   typedef enum logic [1:0] {ST_IDLE, ST_CHARGE, ST_DONE} state_t;
   localparam int HOUR_W = 20;
   localparam int BW = $clog2(BLINK_CYC + 1);
   initial begin
      if (TICKS_PER_HOUR < 1 || TICKS_PER_HOUR * 20 >= 2 ** HOUR_W)
         $error("timebase ticks per hour out of range");
   end
   // ==========================================================
   // synchronise the enable pin
   logic en_meta, en_sync_n, en_prev_n;   // pin synchroniser
   always_ff @(posedge I_CLK_SYS) begin
      en_meta <= I_CHARGE_EN_N;
      en_sync_n <= en_meta;
   end
   // ==========================================================
   // held settings, reset by either reset
   logic cfg_reset;
   assign cfg_reset = I_RESET || I_REG_RESET;
   always_ff @(posedge I_CLK_SYS) begin
      if (cfg_reset) begin
         O_FAST_CUR <= FAST_CUR_RESET;           // [RULE_01]
         O_TIMER_SEL <= TIMER_SEL_RESET;         // [RULE_01]
      end else begin
         if (I_FAST_CUR_WE) O_FAST_CUR <= I_FAST_CUR_WDATA;
         if (I_TIMER_SEL_WE) O_TIMER_SEL <= I_TIMER_SEL_WDATA;
      end
   end
   // ==========================================================
   // decode of conditions
   state_t state, next_state;
   logic timer_fault;                  // safety timer expired
   logic enabled, start_ok, temp_ok, regulating, low_bat;
   logic cool, warm, term_hit, rechg_hit, retoggle;
   logic [12:0] rechg_mv, term_lvl, fast_lim, base_cur, comp_mv;
   logic [20:0] comp_prod;
   logic enable_prev;
   assign enabled = I_CHARGE_ENABLE_BIT && !en_sync_n;
   assign temp_ok = band_t'(I_TEMP_BAND) != BAND_COLD &&
      band_t'(I_TEMP_BAND) != BAND_HOT;                 // [RULE_14]
   assign cool = band_t'(I_TEMP_BAND) == BAND_COOL;
   assign warm = band_t'(I_TEMP_BAND) == BAND_WARM;
   assign start_ok = I_CONV_RUN && enabled && O_FAST_CUR != '0 &&
      temp_ok && !timer_fault && !I_BATTERY_SWITCH_OFF; // [RULE_02]
   assign regulating = I_INPUT_LIMITING || I_THERMAL_REG;
   assign low_bat = I_BAT_MV < I_LOW_BAT_MV;
   assign rechg_mv = I_RECHARGE_SELECT ? I_RECHG_LO_MV : I_RECHG_HI_MV;
   // cool band percentage, shared by current limit and termination
   function automatic logic [12:0] pct(input logic [12:0] v,
                                       input logic half);
      logic [15:0] t;
      t = half ? {3'h0, v} / 16'h0002 : {3'h0, v} / 16'h0005;
      return t[12:0];
   endfunction
   assign term_lvl = cool ? pct(I_TERM_CUR, I_COOL_TERM_REDUCE)
      : I_TERM_CUR;                                     // [RULE_16]
   assign fast_lim = cool ? pct(O_FAST_CUR, I_COOL_CUR_SELECT)
      : O_FAST_CUR;                                     // [RULE_15]
   assign term_hit = state == ST_CHARGE && I_TERM_ENABLE &&
      !regulating && I_BAT_MA < term_lvl &&
      I_BAT_MV > rechg_mv;                              // [RULE_03] [RULE_09] [RULE_12]
   assign rechg_hit = I_BAT_MV < rechg_mv;              // [RULE_04]
   assign retoggle = enabled && !enable_prev;           // [RULE_05]
   // charge current chosen by battery voltage
   assign base_cur = I_BAT_MV < SHORT_LIMIT_MV ? I_SHORT_CUR
      : I_BAT_MV < PRE_LIMIT_MV ? I_PRE_CUR : fast_lim; // [RULE_08]
   // compensation lift is the smaller of I*R and the clamp
   assign comp_prod = 21'(({8'h00, I_BAT_MA} * {13'h0000, I_COMP_RES})
      / 21'd1000);
   assign comp_mv = comp_prod < {8'h00, I_CLAMP_VOLT} ? comp_prod[12:0]
      : I_CLAMP_VOLT;                                   // [RULE_13]
   // ==========================================================
   // cycle state machine
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start_ok) next_state = ST_CHARGE;       // [RULE_02]
         end
         ST_CHARGE: begin
            if (!enabled || timer_fault || I_BATTERY_SWITCH_OFF)
               next_state = ST_IDLE;
            else if (term_hit) next_state = ST_DONE;    // [RULE_03]
         end
         ST_DONE: begin
            if (!enabled) next_state = ST_IDLE;         // [RULE_05]
            else if (rechg_hit && start_ok)
               next_state = ST_CHARGE;                  // [RULE_04]
         end
      endcase
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         state <= ST_IDLE;
         enable_prev <= 1'b0;
         en_prev_n <= 1'b1;
      end else begin
         state <= next_state;
         enable_prev <= enabled;
         en_prev_n <= en_sync_n;
      end
   end
   // ==========================================================
   // safety timer: one tick count compared against hours times ticks per hour
   logic [HOUR_W-1:0] ticks;           // timebase ticks counted
   logic half_skip;                    // alternate tick toggle
   logic adv;                          // timer advances this tick
   logic [HOUR_W-1:0] limit_ticks;
   logic [4:0] limit_hours;
   assign limit_hours = low_bat ? 5'(LOW_BAT_HOURS)     // [RULE_18]
      : O_TIMER_SEL == 2'h0 ? 5'h05 : O_TIMER_SEL == 2'h1 ? 5'h08
      : O_TIMER_SEL == 2'h2 ? 5'h0C : 5'h14;
   assign limit_ticks = HOUR_W'(limit_hours * TICKS_PER_HOUR);
   assign adv = I_TICK && state == ST_CHARGE && I_TIMER_ENABLE &&
      temp_ok && !(regulating && I_HALF_RATE_ENABLE &&
      half_skip);                                 // [RULE_09] [RULE_20] [RULE_24]
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET || state != ST_CHARGE || !I_TIMER_ENABLE) begin
         ticks <= '0;                                   // [RULE_19]
         half_skip <= 1'b0;
      end else begin
         if (I_TICK && regulating) half_skip <= !half_skip; // [RULE_24]
         if (adv) ticks <= ticks + 1'b1;
      end
   end
   // fault held until enable drops or is retoggled; a host read with no fault rearms the pulse
   logic fault_armed, fault_fire, expire;
   assign expire = state == ST_CHARGE && I_TIMER_ENABLE &&
      ticks >= limit_ticks;
   assign fault_fire = expire && fault_armed;           // [RULE_23]
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         timer_fault <= 1'b0;
         fault_armed <= 1'b1;
      end else begin
         if (expire) timer_fault <= 1'b1;               // set wins
         else if (!enabled || retoggle) timer_fault <= 1'b0;
         if (fault_fire) fault_armed <= 1'b0;
         else if (I_FAULT_READ && !timer_fault) fault_armed <= 1'b1;
      end
   end
   // ==========================================================
   // event pulse: termination or first fault
   pulse_stretch #(.LEN(PULSE_CYC)) u_event (
      .i_clk(I_CLK_SYS),
      .i_reset(I_RESET),
      .i_fire(term_hit || fault_fire),            // [RULE_11] [RULE_19] [RULE_23]
      .o_pulse(O_EVENT)
   );
   // ==========================================================
   // monitor sequencer
   monitor_seq #(.PERIOD(MON_CYC)) u_mon (
      .i_clk(I_CLK_SYS),
      .i_reset(I_RESET),
      .i_go_set(I_MON_GO_SET),
      .i_continuous(I_MON_CONTINUOUS),
      .i_charge_mode(state == ST_CHARGE),
      .i_battery_only(!I_CONV_RUN),
      .o_go(O_MON_GO),
      .o_upd_common(O_UPD_COMMON),
      .o_upd_input(O_UPD_INPUT),
      .o_upd_current(O_UPD_CURRENT)
   );
   // ==========================================================
   // blink timer for the indicator fault and suspend states
   logic [BW-1:0] blink_cnt;
   logic blink;
   logic suspended;                    // charge or boost suspend
   assign suspended = timer_fault || (enabled && !temp_ok) ||
      (I_BOOST_MODE && !O_BOOST_RUN);
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         blink_cnt <= '0;
         blink <= 1'b0;
      end else if (blink_cnt == BW'(BLINK_CYC - 1)) begin
         blink_cnt <= '0;
         blink <= !blink;
      end else begin
         blink_cnt <= blink_cnt + 1'b1;
      end
   end
   // ==========================================================
   // registered outputs
   logic charging;
   assign charging = state == ST_CHARGE && temp_ok;     // [RULE_14]
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_PHASE <= PHASE_OFF;
         O_FAULT <= 2'h0;
         O_CUR_TARGET <= '0;
         O_VOLT_TARGET <= '0;
         O_BATTERY_SWITCH_ON <= 1'b0;
         O_BOOST_RUN <= 1'b0;
         O_STAT_OUT <= 1'b0;
         O_STAT_OE <= 1'b0;
      end else begin
         O_PHASE <= state == ST_DONE ? PHASE_DONE       // [RULE_11]
            : state == ST_IDLE ? PHASE_OFF
            : I_BAT_MV < PRE_LIMIT_MV ? PHASE_PRE : PHASE_FAST; // [RULE_07]
         O_FAULT <= timer_fault ? FAULT_TIMER : 2'h0;   // [RULE_19]
         O_CUR_TARGET <= charging ? base_cur : '0;
         O_VOLT_TARGET <= 13'(I_REG_VOLT + comp_mv -
            ((warm && !I_WARM_VOLT_SELECT) ? WARM_DROP_MV : 13'h0000));
         // switch open after termination; supplement closes it
         O_BATTERY_SWITCH_ON <= !I_BATTERY_SWITCH_OFF &&
            (charging || (state != ST_CHARGE && !I_CONV_RUN)); // [RULE_10]
         O_BOOST_RUN <= I_BOOST_MODE && (I_BOOST_TEMP_OK ||
            I_BOOST_HOT_FIELD == BOOST_HOT_OFF);        // [RULE_17]
         O_STAT_OUT <= 1'b0;
         O_STAT_OE <= !I_INDICATOR_DISABLE &&
            (suspended ? blink : charging);             // [RULE_06]
      end
   end
   // ==========================================================
   // checks
   sequence term_seen_s;
      state == ST_CHARGE && next_state == ST_DONE;
   endsequence
   term_phase_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) term_seen_s |=> ##1 O_PHASE == PHASE_DONE
      && O_EVENT) // [RULE_11]
      else $error("termination did not set done and event");
   term_block_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) state == ST_CHARGE && (regulating ||
      !I_TERM_ENABLE) |=> state != ST_DONE) // [RULE_12]
      else $error("termination while inhibited");
   start_gate_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) state == ST_IDLE && !start_ok
      |=> state == ST_IDLE) // [RULE_02]
      else $error("cycle started without conditions");
   fault_code_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) expire |=> ##1 O_FAULT == FAULT_TIMER) // [RULE_19]
      else $error("timer expiry not reported");
   stat_off_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) I_INDICATOR_DISABLE |=> !O_STAT_OE) // [RULE_06]
      else $error("indicator driven while disabled");
   boost_hold_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) I_BOOST_MODE && !I_BOOST_TEMP_OK &&
      I_BOOST_HOT_FIELD != BOOST_HOT_OFF |=> !O_BOOST_RUN) // [RULE_17]
      else $error("boost ran outside window");
   done_switch_a: assert property (@(posedge I_CLK_SYS)
      disable iff (I_RESET) state == ST_DONE && I_CONV_RUN
      |=> !O_BATTERY_SWITCH_ON) // [RULE_10]
      else $error("battery switch closed after termination");
   reset_cur_a: assert property (@(posedge I_CLK_SYS)
      $past(I_RESET) |-> O_FAST_CUR == FAST_CUR_RESET) // [RULE_01]
      else $error("fast current reset value wrong");
endmodule
`default_nettype wire

// ---- charge_ctrl_tb.sv ----
// testbench for the charge cycle controller
`timescale 1ns/1ns
`default_nettype none
module charge_ctrl_tb;
   import charge_pkg::*;
   // ==========================================
   // stimulus and observed signals
   logic I_CLK_SYS = 1'b0, I_RESET = 1'b1, I_TICK = 1'b0, I_REG_RESET = 1'b0;
   logic I_CONV_RUN = 1'b1, I_CHARGE_ENABLE_BIT = 1'b1, I_CHARGE_EN_N = 1'b0;
   // termination held off until the measured current has settled
   logic I_FAST_CUR_WE = 1'b0, I_RECHARGE_SELECT = 1'b0, I_TERM_ENABLE = 1'b0;
   logic I_BATTERY_SWITCH_OFF = 1'b0, I_INPUT_LIMITING = 1'b0, full = 1'b0;
   logic I_THERMAL_REG = 1'b0, I_WARM_VOLT_SELECT = 1'b1, I_BOOST_MODE = 1'b0;
   logic I_COOL_CUR_SELECT = 1'b0, I_COOL_TERM_REDUCE = 1'b0, I_FAULT_READ = 1'b0;
   logic I_BOOST_TEMP_OK = 1'b1, I_TIMER_ENABLE = 1'b1, I_TIMER_SEL_WE = 1'b0;
   logic I_HALF_RATE_ENABLE = 1'b1, I_INDICATOR_DISABLE = 1'b0;
   logic I_MON_GO_SET = 1'b0, I_MON_CONTINUOUS = 1'b0;
   logic [12:0] I_FAST_CUR_WDATA = 13'h0000, I_PRE_CUR = 13'h0080;
   logic [12:0] I_SHORT_CUR = 13'h0064, I_TERM_CUR = 13'h0100;
   logic [12:0] I_REG_VOLT = 13'h1070, I_CLAMP_VOLT = 13'h0000;
   logic [12:0] I_BAT_MV = 13'h0E10, I_RECHG_HI_MV = 13'h0DAC;
   logic [12:0] I_RECHG_LO_MV = 13'h0C80, I_LOW_BAT_MV = 13'h0BB8;
   logic [7:0] I_COMP_RES = 8'h00;
   logic [2:0] I_TEMP_BAND = 3'h2;
   logic [1:0] I_BOOST_HOT_FIELD = 2'h0, I_TIMER_SEL_WDATA = 2'h0;
   logic [12:0] O_FAST_CUR, O_CUR_TARGET, O_VOLT_TARGET, I_BAT_MA;
   logic [1:0] O_TIMER_SEL, O_PHASE, O_FAULT;
   logic O_BATTERY_SWITCH_ON, O_BOOST_RUN, O_STAT_OUT, O_STAT_OE, O_EVENT;
   logic O_MON_GO, O_UPD_COMMON, O_UPD_INPUT, O_UPD_CURRENT;
   int mismatches = 0, check_count = 0, cycles = 0;
   // ==========================================
   // short counts keep the run brief
   charge_ctrl #(.PULSE_CYC(8), .MON_CYC(20), .BLINK_CYC(4),
      .TICKS_PER_HOUR(2)) dut (.*);
   battery_pack pack (.i_clk(I_CLK_SYS), .i_switch_on(O_BATTERY_SWITCH_ON),
      .i_full(full), .i_target(O_CUR_TARGET), .o_bat_ma(I_BAT_MA));
   always #25 I_CLK_SYS = ~I_CLK_SYS;  // 20 MHz
   // hang guard: the sequence needs about 70 cycles
   always @(posedge I_CLK_SYS) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge I_CLK_SYS);
   endtask
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      step(10);
      I_RESET <= 1'b0;
      step(1);
      #1 chk(O_FAST_CUR, 13'h0800);
      chk(O_TIMER_SEL, TIMER_SEL_RESET);
      step(6);
      #1 chk(O_PHASE, PHASE_FAST);
      chk(O_CUR_TARGET, 13'h0800);
      chk(O_STAT_OE, 1'b1);
      chk(O_VOLT_TARGET, 13'h1070);
      $display("start test done");
      step(1);
      chk(O_PHASE, PHASE_FAST);
      full <= 1'b1;  // current tapers below the termination level
      I_TERM_ENABLE <= 1'b1;
      step(5);
      #1 chk(O_EVENT, 1'b1);
      chk(O_PHASE, PHASE_DONE);
      chk(O_BATTERY_SWITCH_ON, 1'b0);
      chk(O_STAT_OE, 1'b0);
      $display("termination test done");
      step(1);
      full <= 1'b0;
      I_BAT_MV <= 13'h0D48;  // 3400 mV, under the recharge level
      step(6);
      #1 chk(O_PHASE, PHASE_FAST);
      $display("recharge test done");
      step(1);
      I_BAT_MV <= 13'h09C4;  // 2500 mV: precharge band
      I_CHARGE_ENABLE_BIT <= 1'b0;
      step(5);
      #1 chk(O_PHASE, PHASE_OFF);
      step(1);
      I_CHARGE_ENABLE_BIT <= 1'b1;
      step(6);
      #1 chk(O_PHASE, PHASE_PRE);
      chk(O_CUR_TARGET, 13'h0080);
      $display("precharge test done");
      step(1);
      I_MON_GO_SET <= 1'b1;
      step(1);
      I_MON_GO_SET <= 1'b0;
      step(2);
      #1 chk(O_MON_GO, 1'b1);
      step(22);
      #1 chk(O_MON_GO, 1'b0);
      $display("monitor test done");
      conclude();
   end
endmodule
`default_nettype wire

// ---- charge_pkg.sv ----
// shared constants for the charge cycle controller
package charge_pkg;
   // code widths: currents in mA codes, voltages in mV codes
   localparam int CUR_W = 13;
   localparam int VOLT_W = 13;
   localparam int TMR_W = 2;
   // values after reset (currents in mA)
   localparam logic [12:0] FAST_CUR_RESET = 13'h0800;  // 2048 mA
   localparam logic [12:0] PRE_CUR_RESET = 13'h0080;   // 128 mA
   localparam logic [12:0] TERM_CUR_RESET = 13'h0100;  // 256 mA
   localparam logic [1:0] TIMER_SEL_RESET = 2'h2;      // 12 hour
   // battery thresholds and warm drop (mV)
   localparam logic [12:0] SHORT_LIMIT_MV = 13'h07D0;  // 2 V
   localparam logic [12:0] PRE_LIMIT_MV = 13'h0BB8;    // 3 V
   localparam logic [12:0] WARM_DROP_MV = 13'h00C8;    // 200 mV
   // phase, fault and boost hot field codes
   localparam logic [1:0] PHASE_OFF = 2'h0;
   localparam logic [1:0] PHASE_PRE = 2'h1;
   localparam logic [1:0] PHASE_FAST = 2'h2;
   localparam logic [1:0] PHASE_DONE = 2'h3;
   localparam logic [1:0] FAULT_TIMER = 2'h3;
   localparam logic [1:0] BOOST_HOT_OFF = 2'h3;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_NS = 50;
   localparam int EVENT_PULSE_NS = 256_000;             // 256 us
   localparam int EVENT_PULSE_CYC = EVENT_PULSE_NS / CLK_NS;
   localparam int MONITOR_PERIOD_MS = 1000;             // 1 second
   localparam int MONITOR_CYC = CLK_HZ / 1000 * MONITOR_PERIOD_MS;
   localparam int LOW_BAT_HOURS = 4;                    // 4 hours
   localparam int BLINK_HALF_CYC = CLK_HZ / 2;          // 1 Hz blink
   // thermistor band codes
   typedef enum logic [2:0] {
      BAND_COLD, BAND_COOL, BAND_NORMAL, BAND_WARM, BAND_HOT
   } band_t;
endpackage

// ---- monitor_seq.sv ----
// monitoring converter sequencer: one-shot and continuous passes
`timescale 1ns/1ns
`default_nettype none
module monitor_seq #(
   parameter int PERIOD = 20_000_000
) (
   input wire logic i_clk,          // system clock
   input wire logic i_reset,        // synchronous reset
   input wire logic i_go_set,       // host sets the go bit
   input wire logic i_continuous,   // continuous mode select
   input wire logic i_charge_mode,  // charging active
   input wire logic i_battery_only, // no input source
   output logic o_go,               // go bit readback
   output logic o_upd_common,       // battery/system/thermistor update
   output logic o_upd_input,        // input voltage update
   output logic o_upd_current       // charge current update
);
   localparam int CW = $clog2(PERIOD + 1);
   logic [CW-1:0] timer;            // cycles into current pass
   logic done;                      // pass completes this cycle
   initial begin
      if (PERIOD < 2) $error("monitor period too short");
   end
   assign done = o_go && (timer == CW'(PERIOD - 1));
   // ==========================================================
   // pass timer; continuous mode keeps go set between passes
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_go <= 1'b0;
         timer <= '0;
      end else if (!o_go) begin
         o_go <= i_go_set || i_continuous;   // [RULE_21] [RULE_22]
         timer <= '0;
      end else if (done) begin
         o_go <= i_continuous;               // self clears [RULE_21]
         timer <= '0;
      end else begin
         timer <= timer + 1'b1;
      end
   end
   // ==========================================================
   // result update strobes; input and current strobes gated by operating mode
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_upd_common <= 1'b0;
         o_upd_input <= 1'b0;
         o_upd_current <= 1'b0;
      end else begin
         o_upd_common <= done;                    // [RULE_25]
         o_upd_input <= done && !i_battery_only;  // [RULE_25]
         o_upd_current <= done && i_charge_mode;  // [RULE_25]
      end
   end
   go_bound_a: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(o_go) && !i_continuous |-> ##[1:PERIOD] !o_go) // [RULE_21]
      else $error("one-shot pass did not finish");
endmodule
`default_nettype wire

// ---- pulse_stretch.sv ----
// fixed-length pulse generator for the host event line
`timescale 1ns/1ns
`default_nettype none
module pulse_stretch #(
   parameter int LEN = 5120
) (
   input wire logic i_clk,      // system clock
   input wire logic i_reset,    // synchronous reset
   input wire logic i_fire,     // one-cycle trigger
   output logic o_pulse         // stretched pulse
);
   localparam int CW = $clog2(LEN + 1);
   logic [CW-1:0] count;        // cycles left in pulse
   initial begin
      if (LEN < 1) $error("pulse length must be positive");
   end
   // ==========================================================
   // counter: a trigger during a pulse restarts it
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         count <= '0;
         o_pulse <= 1'b0;
      end else if (i_fire) begin
         count <= CW'(LEN - 1);
         o_pulse <= 1'b1;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end else begin
         o_pulse <= 1'b0;
      end
   end
endmodule
`default_nettype wire
